// [src/asp_pkg.sv]
package asp_pkg;

  // ==========================================================
  // register map (byte addresses over wishbone)
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_RX_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_TX_BUFFER = 8'h19;
  localparam logic [7:0] ADDR_RX_FIFO = 8'h1a;
  localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] ADDR_TX_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_BAUD_DIVISOR = 8'h99;
  localparam logic [7:0] ADDR_SLEEP_CONTROL = 8'h9c;

  // ==========================================================
  // field positions
  localparam int TXS_CLOCK_SOURCE = 7;
  localparam int TXS_NINE_BIT = 6;
  localparam int TXS_ENABLE = 5;
  localparam int TXS_SYNC = 4;
  localparam int TXS_HIGH_SPEED = 2;
  localparam int TXS_SHIFTER_EMPTY = 1;
  localparam int TXS_NINTH = 0;
  localparam int RCS_PORT_ENABLE = 7;
  localparam int RCS_NINE_BIT = 6;
  localparam int RCS_SINGLE = 5;
  localparam int RCS_CONTINUOUS = 4;
  localparam int RCS_FRAMING = 2;
  localparam int RCS_OVERRUN = 1;
  localparam int RCS_NINTH = 0;
  localparam int IRQ_RX_READY = 5;
  localparam int IRQ_TX_EMPTY = 4;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_TX_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;

  // ==========================================================
  // timing: sub-bit ticks per bit, sample points of the majority vote
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [3:0] SYNC_TICKS_LAST = 4'h3;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [5:0] PRE_LOW = 6'h03;
  localparam logic [5:0] PRE_HIGH = 6'h00;
  localparam logic [5:0] PRE_SYNC = 6'h00;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic framing;
  } asp_rx_word_t;

endpackage : asp_pkg

// [src/asp_top.sv]
`timescale 1ns/1ps
// ==========================================================
// Notes on behaviour
// - baud generator is a free-running 8-bit timer, period from baud divisor
// - async low speed bit rate is clock over 64 times divisor plus one
// - async high speed bit rate is clock over 16 times divisor plus one
// - sync mode ignores high speed; rate is clock over 4 times divisor plus one
// - any divisor write clears the generator timer
// - receive pin sampled three times mid-bit, majority decides; x16 recovery
// - frame is start, 8 or 9 data bits LSB first, stop; shared format
// - generator ticks at x16 bit rate at either high speed setting (the prescaler absorbs the x4), x4 in sync mode
// - all async transmit and receive halt during sleep
// - shifter loads from buffer only after previous stop bit, at once if full
// - buffer-empty flag not software clearable; clears on buffer write, sets on enable
// - read-only shifter-empty status bit, polled, no interrupt
// - transmit needs enable, buffered data and a shift clock; preload works
// - clearing transmit enable aborts frame, resets transmitter, releases pin
// - ninth transmit bit captured at shifter load; write it before the data
// - async receiver runs only while continuous receive enable is set
// - after stop bit word goes to fifo if room; ready flag clears when empty
// - two-word fifo; stop bit with fifo full always drops the word; it sets overrun unless a fifo read lands in the same cycle
// - overrun blocks transfers; cleared only by clearing continuous receive
// - framing error set when stop bit sampled as zero
// - framing and ninth bit queued per word; read status before data
// - serial port enable hands pins to the port; clear disables it
// - nine-bit receive select picks nine or eight bit reception
// - generator held in reset while transmit, continuous and single enables clear
module asp_top (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [7:0] wb_dat_in,
  input wire logic wb_we_in,
  input wire logic wb_sel_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  output logic [7:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic receive_pin_in,
  output logic transmit_pin_out,
  output logic transmit_pin_oe_out,
  output logic irq_out
);
  // ==========================================================
  // registers and bus decode
  logic [7:0] txsc_ff, rcsc_ff, baud_ff, ien_ff, txbuf_ff;
  logic sleep_ff, txbuf_full_ff, tx_empty_flag_ff, ack_ff;
  logic [7:0] rdata_ff;
  logic wr, rd;
  logic tx_en, rx_en, high_speed, sync_mode, port_en;
  logic tx_load, fifo_pop, fifo_push, rx_ready;
  asp_pkg::asp_rx_word_t fifo_mem [2];
  logic [1:0] fifo_cnt_ff;
  logic fifo_rp_ff, fifo_wp_ff, overrun_ff;
  logic tsr_busy_ff;

  assign wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in && !ack_ff;
  assign rd = wb_cyc_in && wb_stb_in && !wb_we_in && !ack_ff;
  assign tx_en = txsc_ff[asp_pkg::TXS_ENABLE];
  assign rx_en = rcsc_ff[asp_pkg::RCS_CONTINUOUS];
  assign high_speed = txsc_ff[asp_pkg::TXS_HIGH_SPEED];
  assign sync_mode = txsc_ff[asp_pkg::TXS_SYNC];
  assign port_en = rcsc_ff[asp_pkg::RCS_PORT_ENABLE];
  assign fifo_pop = rd && wb_adr_in == asp_pkg::ADDR_RX_FIFO && fifo_cnt_ff != 2'h0;
  assign rx_ready = fifo_cnt_ff != 2'h0;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = a == r;
  endfunction : hit
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      ack_ff <= 1'b0;
    else
      ack_ff <= wb_cyc_in && wb_stb_in && !ack_ff;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      txsc_ff <= asp_pkg::RST_TX_STATUS_CONTROL;
      rcsc_ff <= 8'h00;
      baud_ff <= asp_pkg::RST_BAUD_DIVISOR;
      ien_ff <= 8'h00;
      sleep_ff <= 1'b0;
    end
    else if (wr)
    begin
      // status bits are not stored here; they are merged on read
      if (hit(wb_adr_in, asp_pkg::ADDR_TX_STATUS_CONTROL))
        txsc_ff <= wb_dat_in & 8'hf5;
      if (hit(wb_adr_in, asp_pkg::ADDR_RX_STATUS_CONTROL))
        rcsc_ff <= wb_dat_in & 8'hf0;
      if (hit(wb_adr_in, asp_pkg::ADDR_BAUD_DIVISOR))
        baud_ff <= wb_dat_in;
      if (hit(wb_adr_in, asp_pkg::ADDR_IRQ_ENABLES))
        ien_ff <= wb_dat_in;
      if (hit(wb_adr_in, asp_pkg::ADDR_SLEEP_CONTROL))
        sleep_ff <= wb_dat_in[0];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_ff <= 8'h00;
    else if (rd)
    begin
      unique case (wb_adr_in)
        asp_pkg::ADDR_TX_STATUS_CONTROL:
          rdata_ff <= {txsc_ff[7:2], !tsr_busy_ff, txsc_ff[0]};
        asp_pkg::ADDR_RX_STATUS_CONTROL:
          rdata_ff <= {rcsc_ff[7:4], 1'b0, fifo_mem[fifo_rp_ff].framing, overrun_ff,
                       fifo_mem[fifo_rp_ff].ninth};
        asp_pkg::ADDR_RX_FIFO: rdata_ff <= fifo_mem[fifo_rp_ff].data;
        asp_pkg::ADDR_TX_BUFFER: rdata_ff <= txbuf_ff;
        asp_pkg::ADDR_BAUD_DIVISOR: rdata_ff <= baud_ff;
        asp_pkg::ADDR_IRQ_ENABLES: rdata_ff <= ien_ff;
        asp_pkg::ADDR_IRQ_FLAGS: rdata_ff <= {2'b00, rx_ready, tx_empty_flag_ff, 4'h0};
        asp_pkg::ADDR_SLEEP_CONTROL: rdata_ff <= {7'h00, sleep_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end
  assign wb_dat_out = rdata_ff;
  assign wb_ack_out = ack_ff;
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= (rx_ready && ien_ff[asp_pkg::IRQ_RX_READY])
              || (tx_empty_flag_ff && ien_ff[asp_pkg::IRQ_TX_EMPTY]);
  end

  // ==========================================================
  // baud rate generator: prescaler then 8-bit timer
  logic [5:0] pre_ff;
  logic [7:0] brg_ff;
  logic brg_run, pre_tick, tick;
  logic [5:0] pre_last;
  assign brg_run = (tx_en || rx_en || rcsc_ff[asp_pkg::RCS_SINGLE]) && !sleep_ff;
  // prescale: x64 low speed -> /4 then timer; x16 high speed -> /1 (sync /1 too)
  assign pre_last = sync_mode ? asp_pkg::PRE_SYNC
                  : (high_speed ? asp_pkg::PRE_HIGH : asp_pkg::PRE_LOW);
  assign pre_tick = pre_ff == pre_last;
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pre_ff <= 6'h00;
      brg_ff <= 8'h00;
    end
    else if (!brg_run || (wr && hit(wb_adr_in, asp_pkg::ADDR_BAUD_DIVISOR)))
    begin
      pre_ff <= 6'h00;
      brg_ff <= 8'h00;
    end
    else
    begin
      pre_ff <= pre_tick ? 6'h00 : pre_ff + 6'h01;
      if (pre_tick)
        brg_ff <= (brg_ff == baud_ff) ? 8'h00 : brg_ff + 8'h01;
    end
  end
  // tick is clk / (4*(n+1)) low speed, / (n+1) high speed or sync; sync bits are 4 ticks long
  assign tick = brg_run && pre_tick && brg_ff == baud_ff;
  // ==========================================================
  // transmitter
  logic [9:0] tsr_ff;
  logic [3:0] tx_sub_ff, tx_bits_ff, tx_last;
  logic tx_line_ff;
  assign tx_load = tx_en && port_en && txbuf_full_ff && !tsr_busy_ff && tick;
  assign tx_last = sync_mode ? asp_pkg::SYNC_TICKS_LAST : asp_pkg::TICKS_LAST;
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      txbuf_ff <= 8'h00;
      txbuf_full_ff <= 1'b0;
      tx_empty_flag_ff <= 1'b0;
    end
    else if (wr && hit(wb_adr_in, asp_pkg::ADDR_TX_BUFFER))
    begin
      txbuf_ff <= wb_dat_in;
      txbuf_full_ff <= 1'b1;
      tx_empty_flag_ff <= 1'b0;
    end
    else if (tx_load)
    begin
      txbuf_full_ff <= 1'b0;
      tx_empty_flag_ff <= 1'b1;
    end
    else if (tx_en && !txbuf_full_ff)
      tx_empty_flag_ff <= 1'b1;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tsr_ff <= 10'h3ff;
      tsr_busy_ff <= 1'b0;
      tx_sub_ff <= 4'h0;
      tx_bits_ff <= 4'h0;
      tx_line_ff <= 1'b1;
    end
    else if (!tx_en)
    begin
      tsr_busy_ff <= 1'b0;
      tx_line_ff <= 1'b1;
      tx_sub_ff <= 4'h0;
      tx_bits_ff <= 4'h0;
    end
    else if (tx_load)
    begin
      // ninth bit taken now, so it must be written before the data
      tsr_ff <= {1'b1, txsc_ff[asp_pkg::TXS_NINTH], txbuf_ff};
      tsr_busy_ff <= 1'b1;
      tx_line_ff <= 1'b0; // start bit
      tx_sub_ff <= 4'h0;
      tx_bits_ff <= txsc_ff[asp_pkg::TXS_NINE_BIT] ? 4'ha : 4'h9;
    end
    else if (tsr_busy_ff && tick)
    begin
      tx_sub_ff <= (tx_sub_ff == tx_last) ? 4'h0 : tx_sub_ff + 4'h1;
      if (tx_sub_ff == tx_last)
      begin
        if (tx_bits_ff == 4'h0)
          tsr_busy_ff <= 1'b0;
        else
        begin
          tx_line_ff <= (tx_bits_ff == 4'h1) ? 1'b1 : tsr_ff[0]; // lsb first
          tsr_ff <= {1'b1, tsr_ff[9:1]};
          if (tx_bits_ff == 4'h2 && !txsc_ff[asp_pkg::TXS_NINE_BIT])
            tsr_ff <= 10'h3ff;
          tx_bits_ff <= tx_bits_ff - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      transmit_pin_out <= 1'b1;
      transmit_pin_oe_out <= 1'b0;
    end
    else
    begin
      transmit_pin_out <= tx_line_ff;
      transmit_pin_oe_out <= port_en && tx_en;
    end
  end

  // ==========================================================
  // receiver: synchroniser, x16 recovery, majority vote
  logic rx_s1_ff, rx_s2_ff;
  logic [2:0] vote_ff;
  logic [3:0] rx_sub_ff, rx_bits_ff;
  logic [8:0] rsr_ff;
  logic rx_busy_ff, maj, rx_active;
  assign rx_active = rx_en && port_en && !sleep_ff;
  assign maj = (vote_ff[0] & vote_ff[1]) | (vote_ff[1] & vote_ff[2])
             | (vote_ff[0] & vote_ff[2]);
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
    end
    else
    begin
      rx_s1_ff <= receive_pin_in;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_busy_ff <= 1'b0;
      rx_sub_ff <= 4'h0;
      rx_bits_ff <= 4'h0;
      rsr_ff <= 9'h000;
      vote_ff <= 3'h7;
    end
    else if (!rx_en)
    begin
      rx_busy_ff <= 1'b0;
      rx_sub_ff <= 4'h0;
    end
    else if (rx_active && tick)
    begin
      if (!rx_busy_ff)
      begin
        if (!rx_s2_ff)
        begin
          rx_busy_ff <= 1'b1;
          rx_sub_ff <= 4'h1;
          rx_bits_ff <= 4'h0;
        end
      end
      else
      begin
        rx_sub_ff <= rx_sub_ff + 4'h1;
        if (rx_sub_ff == asp_pkg::SAMPLE_A)
          vote_ff[0] <= rx_s2_ff;
        if (rx_sub_ff == asp_pkg::SAMPLE_B)
          vote_ff[1] <= rx_s2_ff;
        if (rx_sub_ff == asp_pkg::SAMPLE_C)
          vote_ff[2] <= rx_s2_ff;
        if (rx_sub_ff == asp_pkg::TICKS_LAST)
        begin
          rx_bits_ff <= rx_bits_ff + 4'h1;
          if (rx_bits_ff == 4'h0 && maj)
            rx_busy_ff <= 1'b0; // false start
          else if (rx_bits_ff != 4'h0)
          begin
            if (rx_bits_ff == (rcsc_ff[asp_pkg::RCS_NINE_BIT] ? 4'ha : 4'h9))
              rx_busy_ff <= 1'b0;
            else
              rsr_ff <= {maj, rsr_ff[8:1]}; // lsb first
          end
        end
      end
    end
  end

  logic stop_done;
  assign stop_done = rx_active && tick && rx_busy_ff && rx_sub_ff == asp_pkg::TICKS_LAST
                   && rx_bits_ff == (rcsc_ff[asp_pkg::RCS_NINE_BIT] ? 4'ha : 4'h9);
  assign fifo_push = stop_done && !overrun_ff && fifo_cnt_ff != 2'h2;
  asp_pkg::asp_rx_word_t rx_word;
  always_comb
  begin
    rx_word.ninth = rcsc_ff[asp_pkg::RCS_NINE_BIT] ? rsr_ff[8] : 1'b0;
    rx_word.data = rcsc_ff[asp_pkg::RCS_NINE_BIT] ? rsr_ff[7:0] : rsr_ff[8:1];
    rx_word.framing = !maj;
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (fifo_push)
      fifo_mem[fifo_wp_ff] <= rx_word;
  end
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fifo_cnt_ff <= 2'h0;
      fifo_rp_ff <= 1'b0;
      fifo_wp_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end
    else
    begin
      if (!rx_en)
        overrun_ff <= 1'b0;
      else if (stop_done && fifo_cnt_ff == 2'h2 && !fifo_pop)
        overrun_ff <= 1'b1;
      if (fifo_push)
        fifo_wp_ff <= !fifo_wp_ff;
      if (fifo_pop)
        fifo_rp_ff <= !fifo_rp_ff;
      fifo_cnt_ff <= fifo_cnt_ff + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  // ==========================================================
  // checks
  AST_TX_EMPTY_FLAG: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (tx_load && !(wr && hit(wb_adr_in, asp_pkg::ADDR_TX_BUFFER))) |=> tx_empty_flag_ff
    && !txbuf_full_ff) else $error("flag not set after load");
  AST_BUF_WRITE_CLEARS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (wr && wb_adr_in == asp_pkg::ADDR_TX_BUFFER) |=> !tx_empty_flag_ff)
    else $error("buffer write did not clear flag");
  AST_ABORT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !tx_en |=> !tsr_busy_ff && !transmit_pin_oe_out) else $error("abort failed");
  AST_DIV_RESET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (wr && wb_adr_in == asp_pkg::ADDR_BAUD_DIVISOR) |=> brg_ff == 8'h00)
    else $error("divisor write did not clear timer");
  AST_BRG_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !brg_run |=> pre_ff == 6'h00 && brg_ff == 8'h00) else $error("generator not held");
  AST_OVERRUN: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (stop_done && fifo_cnt_ff == 2'h2 && !fifo_pop && rx_en) |=> overrun_ff)
    else $error("overrun not flagged");
  AST_NO_PUSH_OVERRUN: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    overrun_ff |-> !fifo_push) else $error("push during overrun");
  AST_NO_LOAD_BUSY: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    tsr_busy_ff |-> !tx_load) else $error("load while shifter busy");
  AST_FIFO_BOUND: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    fifo_cnt_ff <= 2'h2) else $error("fifo count out of range");

endmodule : asp_top

// [sim/asp_remote.sv]
`timescale 1ns/1ps
// ==========================================================
// remote transceiver: drives frames into the receive pin, collects frames from the transmit pin
module asp_remote (
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic oe_in,
  output logic line_out
);
  int bit_clks = 16;
  logic nine = 1'b0;
  logic [9:0] rx_q[$];

  initial line_out = 1'b1;

  // ==========================================================
  // send: start, data lsb first, optional ninth, stop, one idle bit
  task automatic send(input logic [8:0] d, input logic stop);
    int i;
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge clk_in);
    for (i = 0; i < (nine ? 9 : 8); i++)
    begin
      line_out <= d[i];
      repeat (bit_clks) @(posedge clk_in);
    end
    line_out <= stop;
    repeat (bit_clks) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (bit_clks) @(posedge clk_in);
  endtask : send

  // ==========================================================
  // collect {stop, ninth, data}; a frame cut short by a released pin is dropped
  initial
  begin : mon
    int i;
    int j;
    logic ok;
    logic [9:0] w;
    forever
    begin
      @(posedge clk_in);
      if (oe_in === 1'b1 && line_in === 1'b0)
      begin
        ok = 1'b1;
        w = 10'h000;
        // the enable is watched every clock so an aborted frame frees the monitor at once
        for (i = 0; i < (nine ? 10 : 9) && ok; i++)
        begin
          for (j = 0; j < (i == 0 ? bit_clks + bit_clks / 2 : bit_clks) && ok; j++)
          begin
            @(posedge clk_in);
            ok = ok & (oe_in === 1'b1);
          end
          w[i] = line_in;
        end
        if (ok)
          rx_q.push_back(nine ? w : {w[8], 1'b0, w[7:0]});
      end
    end
  end
endmodule : asp_remote

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] wb_adr = 8'h00;
  logic [7:0] wb_dat = 8'h00;
  logic wb_we = 1'b0;
  logic wb_sel = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic [7:0] wb_dat_out;
  logic wb_ack_out;
  logic rx_line;
  logic tx_pin;
  logic tx_oe;
  logic irq;
  logic tx_line;
  int error_cnt = 0;
  int n_tests = 0;
  logic [8:0] sent_q[$];
  logic [7:0] txs[3] = '{8'h24, 8'h20, 8'h34};
  logic [7:0] divs[3] = '{8'h00, 8'h01, 8'h02};

  // a released pin floats high through the board pull-up
  assign tx_line = tx_oe ? tx_pin : 1'b1;

  asp_top u_asp_top (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_adr_in(wb_adr),
    .wb_dat_in(wb_dat), .wb_we_in(wb_we), .wb_sel_in(wb_sel), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .receive_pin_in(rx_line), .transmit_pin_out(tx_pin), .transmit_pin_oe_out(tx_oe),
    .irq_out(irq));
  asp_remote u_asp_remote (.clk_in(clk_sys_in), .line_in(tx_line), .oe_in(tx_oe),
    .line_out(rx_line));

  initial
  begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // ==========================================================
  // helpers
  function automatic int clks(input logic [7:0] t, input logic [7:0] dv);
    return (int'(dv) + 1) * (t[asp_pkg::TXS_SYNC] ? 4 : (t[asp_pkg::TXS_HIGH_SPEED] ? 16 : 64));
  endfunction : clks

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] dt,
                    output logic [7:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 1'b1;
    wb_adr <= a;
    wb_dat <= dt;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    rd = wb_dat_out;
    if (wb_ack_out !== 1'b1)
      error_cnt++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    logic [7:0] d;
    wb(1'b1, a, dt, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    wb(1'b0, a, 8'h00, d);
    chk({2'b00, d & m}, {2'b00, e});
  endtask : rd_chk

  task automatic tx_send(input logic [8:0] d);
    sent_q.push_back(d);
    wr(asp_pkg::ADDR_TX_BUFFER, d[7:0]);
  endtask : tx_send

  task automatic tx_chk;
    int t;
    logic [9:0] got;
    t = 0;
    got = 'x;
    while (u_asp_remote.rx_q.size() == 0 && t < 5000)
    begin
      @(posedge clk_sys_in);
      t++;
    end
    if (u_asp_remote.rx_q.size() > 0)
      got = u_asp_remote.rx_q.pop_front();
    chk(got, {1'b1, sent_q.pop_front()});
  endtask : tx_chk

  task automatic rx_send(input logic [8:0] d, input logic stop);
    u_asp_remote.send(d, stop);
    repeat (4) @(posedge clk_sys_in);
  endtask : rx_send

  initial
  begin
    repeat (90000) @(posedge clk_sys_in);
    error_cnt++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial
  begin : main
    logic [8:0] d;
    logic [8:0] rw[3];
    int i;
    d = 9'($urandom(32'h0bc9caf3));
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rd_chk(asp_pkg::ADDR_TX_STATUS_CONTROL, 8'hff, asp_pkg::RST_TX_STATUS_CONTROL);
    rd_chk(asp_pkg::ADDR_BAUD_DIVISOR, 8'hff, asp_pkg::RST_BAUD_DIVISOR);
    rd_chk(asp_pkg::ADDR_IRQ_FLAGS, 8'hff, 8'h00);
    rd_chk(asp_pkg::ADDR_IRQ_ENABLES, 8'hff, 8'h00);
    wr(8'h55, 8'ha5);
    rd_chk(8'h55, 8'hff, 8'h00);
    wr(asp_pkg::ADDR_RX_STATUS_CONTROL, 8'h90);
    for (i = 0; i < 3; i++)
    begin
      wr(asp_pkg::ADDR_BAUD_DIVISOR, divs[i]);
      wr(asp_pkg::ADDR_TX_STATUS_CONTROL, txs[i]);
      u_asp_remote.bit_clks = clks(txs[i], divs[i]);
      tx_send({1'b0, 8'($urandom)});
      tx_chk();
    end
    wr(asp_pkg::ADDR_BAUD_DIVISOR, 8'h00);
    wr(asp_pkg::ADDR_TX_STATUS_CONTROL, 8'h24);
    u_asp_remote.bit_clks = clks(8'h24, 8'h00);
    wr(asp_pkg::ADDR_IRQ_FLAGS, 8'h00);
    rd_chk(asp_pkg::ADDR_IRQ_FLAGS, 8'h10, 8'h10);
    tx_send({1'b0, 8'($urandom)});
    tx_send({1'b0, 8'($urandom)});
    rd_chk(asp_pkg::ADDR_IRQ_FLAGS, 8'h10, 8'h00);
    rd_chk(asp_pkg::ADDR_TX_STATUS_CONTROL, 8'h02, 8'h00);
    tx_chk();
    tx_chk();
    repeat (32) @(posedge clk_sys_in);
    rd_chk(asp_pkg::ADDR_IRQ_FLAGS, 8'h10, 8'h10);
    rd_chk(asp_pkg::ADDR_TX_STATUS_CONTROL, 8'h02, 8'h02);
    wr(asp_pkg::ADDR_IRQ_ENABLES, 8'h10);
    repeat (2) @(posedge clk_sys_in);
    chk({9'h000, irq}, 10'h001);
    wr(asp_pkg::ADDR_IRQ_ENABLES, 8'h00);
    repeat (2) @(posedge clk_sys_in);
    chk({9'h000, irq}, 10'h000);
    // ninth bit goes in before the data byte
    wr(asp_pkg::ADDR_TX_STATUS_CONTROL, 8'h65);
    u_asp_remote.nine = 1'b1;
    tx_send({1'b1, 8'($urandom)});
    tx_chk();
    u_asp_remote.nine = 1'b0;
    wr(asp_pkg::ADDR_TX_STATUS_CONTROL, 8'h24);
    tx_send({1'b0, 8'($urandom)});
    repeat (40) @(posedge clk_sys_in);
    wr(asp_pkg::ADDR_TX_STATUS_CONTROL, 8'h04);
    d = sent_q.pop_front();
    chk({9'h000, tx_oe}, 10'h000);
    rd_chk(asp_pkg::ADDR_TX_STATUS_CONTROL, 8'h02, 8'h02);
    tx_send({1'b0, 8'($urandom)});
    wr(asp_pkg::ADDR_TX_STATUS_CONTROL, 8'h24);
    tx_chk();
    // receive: two words fill the fifo, a third overruns
    for (i = 0; i < 3; i++)
    begin
      rw[i] = {1'b0, 8'($urandom)};
      rx_send(rw[i], 1'b1);
    end
    rd_chk(asp_pkg::ADDR_RX_STATUS_CONTROL, 8'h06, 8'h02);
    rd_chk(asp_pkg::ADDR_IRQ_FLAGS, 8'h20, 8'h20);
    rd_chk(asp_pkg::ADDR_RX_FIFO, 8'hff, rw[0][7:0]);
    rd_chk(asp_pkg::ADDR_RX_FIFO, 8'hff, rw[1][7:0]);
    rd_chk(asp_pkg::ADDR_IRQ_FLAGS, 8'h20, 8'h00);
    rx_send({1'b0, 8'($urandom)}, 1'b1);
    rd_chk(asp_pkg::ADDR_IRQ_FLAGS, 8'h20, 8'h00);
    wr(asp_pkg::ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(asp_pkg::ADDR_RX_STATUS_CONTROL, 8'h90);
    rd_chk(asp_pkg::ADDR_RX_STATUS_CONTROL, 8'h02, 8'h00);
    d = {1'b0, 8'($urandom)};
    rx_send(d, 1'b0);
    rd_chk(asp_pkg::ADDR_RX_STATUS_CONTROL, 8'h04, 8'h04);
    rd_chk(asp_pkg::ADDR_RX_FIFO, 8'hff, d[7:0]);
    wr(asp_pkg::ADDR_RX_STATUS_CONTROL, 8'hd0);
    u_asp_remote.nine = 1'b1;
    d = {1'b1, 8'($urandom)};
    rx_send(d, 1'b1);
    rd_chk(asp_pkg::ADDR_RX_STATUS_CONTROL, 8'h05, 8'h01);
    rd_chk(asp_pkg::ADDR_RX_FIFO, 8'hff, d[7:0]);
    wr(asp_pkg::ADDR_SLEEP_CONTROL, 8'h01);
    rx_send(d, 1'b1);
    rd_chk(asp_pkg::ADDR_IRQ_FLAGS, 8'h20, 8'h00);
    wr(asp_pkg::ADDR_SLEEP_CONTROL, 8'h00);
    wr(asp_pkg::ADDR_RX_STATUS_CONTROL, 8'hc0);
    rx_send(d, 1'b1);
    rd_chk(asp_pkg::ADDR_IRQ_FLAGS, 8'h20, 8'h00);
    wr(asp_pkg::ADDR_RX_STATUS_CONTROL, 8'h00);
    repeat (2) @(posedge clk_sys_in);
    chk({9'h000, tx_oe}, 10'h000);
    print_verdict();
  end
endmodule : tb_top
